// file: logic/isc_defs.svh
// Offsets, field positions, reset values and event bits of the serial source control block
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH

// ==========================================================
// Frame layout
`define ISC_FRAME_W 24
`define ISC_LEVEL_LSB 0
`define ISC_LEVEL_W 12
`define ISC_SIGN_BIT 12
`define ISC_COMP_LSB 13
`define ISC_COMP_W 8
`define ISC_RANGE_LSB 21
`define ISC_RANGE_W 3

// ==========================================================
// Register map
`define ISC_ADDR_STATUS 2'h0
`define ISC_ADDR_MASK 2'h1
`define ISC_ADDR_STATE 2'h2
`define ISC_ADDR_RANGE 2'h3

// ==========================================================
// Event bits and reset values
`define ISC_EV_VLIMIT 0
`define ISC_EV_STORED 1
`define ISC_EV_PWRLOSS 2
`define ISC_EV_W 3
`define ISC_FRAME_RST 24'h000000
`define ISC_EV_RST 3'h0
`define ISC_DATA_RST 8'h00
`define ISC_SYNC_RST 4'h0

`endif

// file: logic/isc_pkg.sv
// Types shared by the serial source control block
package isc_pkg;
    typedef enum logic [2:0] {
        ISC_RNG_R0A = 3'b000,
        ISC_RNG_R0B = 3'b001,
        ISC_RNG_R1 = 3'b010,
        ISC_RNG_R2A = 3'b011,
        ISC_RNG_R2B = 3'b100,
        ISC_RNG_R3 = 3'b101,
        ISC_RNG_R4A = 3'b110,
        ISC_RNG_R4B = 3'b111
    } isc_range_e;
    typedef logic [23:0] isc_frame_t;
endpackage

// file: logic/isc_limit_cmp.sv
// Window comparator: measured output voltage against the programmed compliance
module isc_limit_cmp
    import isc_pkg::*;
(
    input wire logic [8:0] meas_volt_i,
    input wire logic [7:0] comp_code_i,
    output logic over_o
);
    logic [8:0] mag;

    // Both polarities: magnitude of a two's complement reading
    always_comb begin
        if (meas_volt_i[8]) begin
            mag = 9'(~meas_volt_i + 9'h001);
        end else begin
            mag = meas_volt_i;
        end
        over_o = (mag > {1'b0, comp_code_i});
    end
endmodule

// file: logic/isc_ctrl.sv
// Analog side control port: serial chain, stored settings, limit flag, power-event hold
//
// Contract
// - Serial control bits become parallel outputs via shift-and-store chain.
// - Shift on serial clock, transfer to stored outputs by latch.
// - Latch low: data-in returns bits recirculated from chain end.
// - Latch high: data-in returns over-compliance flag.
// - Flag high when output is in voltage limit, else low.
// - Flip-flop holds parallel outputs high impedance during power events.
// - Output level from 12-bit converter code of stored outputs.
// - Sign bit selects converter path gain plus one or minus one.
// - Compliance from 8-bit converter code, one volt per step.
// - Limit asserted only when output exceeds compliance, either polarity.
// - Range outputs close one of five relays plus resistor switch.
`include "isc_defs.svh"
module isc_ctrl
    import isc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic latch_i,
    input wire logic sdo_i,
    input wire logic pwr_ok_i,
    input wire logic [8:0] meas_volt_i,
    output logic sdi_o,
    output logic [11:0] level_code_o,
    output logic sign_neg_o,
    output logic [7:0] comp_code_o,
    output logic [4:0] range_relay_o,
    output logic [1:0] range_sw_o,
    output logic par_oe_o,
    output logic vlimit_o,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o
);
    // ==========================================================
    // Pin synchronisers: sclk, latch, sdo, pwr_ok
    logic [3:0] pins;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] prev_reg;

    assign pins = {pwr_ok_i, sdo_i, latch_i, sclk_i};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    prev_reg[gi] <= 1'b0;
                end else if (ce_i) begin
                    sync1_reg[gi] <= pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    prev_reg[gi] <= sync2_reg[gi];
                end
            end
        end
    endgenerate

    logic sclk_s;
    logic latch_s;
    logic sdo_s;
    logic pwr_s;
    logic sclk_rise;
    logic latch_rise;
    logic pwr_fall;

    assign sclk_s = sync2_reg[0];
    assign latch_s = sync2_reg[1];
    assign sdo_s = sync2_reg[2];
    assign pwr_s = sync2_reg[3];
    assign sclk_rise = sclk_s && !prev_reg[0];
    assign latch_rise = latch_s && !prev_reg[1];
    assign pwr_fall = !pwr_s && prev_reg[3];

    // ==========================================================
    // Shift/store chain, hold flop, limit flag, return line
    isc_frame_t shift_reg;
    isc_frame_t shift_next;
    isc_frame_t par_reg;
    isc_frame_t par_next;
    logic hiz_reg;
    logic hiz_next;
    logic vlim_reg;
    logic vlim_next;
    logic sdi_reg;
    logic sdi_next;
    logic over_w;

    isc_limit_cmp u_limit_window_comparator (
        .meas_volt_i(meas_volt_i),
        .comp_code_i(par_reg[`ISC_COMP_LSB +: `ISC_COMP_W]),
        .over_o(over_w)
    );

    always_comb begin
        shift_next = shift_reg;
        par_next = par_reg;
        hiz_next = hiz_reg;
        if (sclk_rise) begin
            shift_next = {shift_reg[`ISC_FRAME_W-2:0], sdo_s};
        end
        if (latch_rise) begin
            par_next = shift_reg;
        end
        // Outputs stay floating until a fresh frame is stored after power returns
        if (!pwr_s) begin
            hiz_next = 1'b1;
        end else if (latch_rise) begin
            hiz_next = 1'b0;
        end
        vlim_next = over_w;
        // True level is sent; the far side undoes its own inversion
        if (latch_s) begin
            sdi_next = vlim_reg;
        end else begin
            sdi_next = shift_reg[`ISC_FRAME_W-1];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_reg <= `ISC_FRAME_RST;
            par_reg <= `ISC_FRAME_RST;
            hiz_reg <= 1'b1;
            vlim_reg <= 1'b0;
            sdi_reg <= 1'b0;
        end else if (ce_i) begin
            shift_reg <= shift_next;
            par_reg <= par_next;
            hiz_reg <= hiz_next;
            vlim_reg <= vlim_next;
            sdi_reg <= sdi_next;
        end
    end

    // ==========================================================
    // Parallel settings
    isc_range_e range_code;

    assign range_code = isc_range_e'(par_reg[`ISC_RANGE_LSB +: `ISC_RANGE_W]);
    assign level_code_o = par_reg[`ISC_LEVEL_LSB +: `ISC_LEVEL_W];
    assign sign_neg_o = par_reg[`ISC_SIGN_BIT];
    assign comp_code_o = par_reg[`ISC_COMP_LSB +: `ISC_COMP_W];
    assign par_oe_o = !hiz_reg;
    assign vlimit_o = vlim_reg;
    assign sdi_o = sdi_reg;

    // Shared relays also pick one resistor via its switch
    always_comb begin
        range_relay_o = 5'h00;
        range_sw_o = 2'h0;
        unique case (range_code)
            ISC_RNG_R0A: begin
                range_relay_o = 5'h01;
                range_sw_o = 2'h1;
            end
            ISC_RNG_R0B: begin
                range_relay_o = 5'h01;
                range_sw_o = 2'h2;
            end
            ISC_RNG_R1: begin
                range_relay_o = 5'h02;
            end
            ISC_RNG_R2A: begin
                range_relay_o = 5'h04;
                range_sw_o = 2'h1;
            end
            ISC_RNG_R2B: begin
                range_relay_o = 5'h04;
                range_sw_o = 2'h2;
            end
            ISC_RNG_R3: begin
                range_relay_o = 5'h08;
            end
            ISC_RNG_R4A: begin
                range_relay_o = 5'h10;
                range_sw_o = 2'h1;
            end
            ISC_RNG_R4B: begin
                range_relay_o = 5'h10;
                range_sw_o = 2'h2;
            end
        endcase
    end

    // ==========================================================
    // Register port and interrupt
    logic [`ISC_EV_W-1:0] status_reg;
    logic [`ISC_EV_W-1:0] status_next;
    logic [`ISC_EV_W-1:0] mask_reg;
    logic [`ISC_EV_W-1:0] mask_next;
    logic [`ISC_EV_W-1:0] events;
    logic [`ISC_EV_W-1:0] clr;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    assign events = {pwr_fall, latch_rise, vlim_next && !vlim_reg};

    always_comb begin
        clr = '0;
        mask_next = mask_reg;
        rdata_next = `ISC_DATA_RST;
        if (wr_i && addr_i == `ISC_ADDR_STATUS) begin
            clr = wdata_i[`ISC_EV_W-1:0];
        end
        if (wr_i && addr_i == `ISC_ADDR_MASK) begin
            mask_next = wdata_i[`ISC_EV_W-1:0];
        end
        // New event beats a clear in the same cycle
        status_next = (status_reg & ~clr) | events;
        if (rd_i) begin
            unique case (addr_i)
                `ISC_ADDR_STATUS: rdata_next = {5'h00, status_reg};
                `ISC_ADDR_MASK: rdata_next = {5'h00, mask_reg};
                `ISC_ADDR_STATE: rdata_next = {4'h0, sign_neg_o, hiz_reg, latch_s, vlim_reg};
                `ISC_ADDR_RANGE: rdata_next = {5'h00, range_code};
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_reg <= `ISC_EV_RST;
            mask_reg <= `ISC_EV_RST;
            rdata_reg <= `ISC_DATA_RST;
        end else if (ce_i) begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign irq_o = |(status_reg & mask_reg);

    // ==========================================================
    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_store;
        ce_i && latch_rise;
    endsequence
    sequence s_shift;
        ce_i && sclk_rise;
    endsequence

    AST_SHIFT_IN: assert property (s_shift |=> shift_reg[0] == $past(sdo_s))
        else $error("serial bit not shifted in");
    AST_CHAIN_MOVE: assert property (s_shift |=> shift_reg[23] == $past(shift_reg[22]))
        else $error("chain did not advance");
    AST_RECIRC: assert property (ce_i && !latch_s |=> sdi_o == $past(shift_reg[23]))
        else $error("recirculated bit wrong");
    AST_FLAG_OUT: assert property (ce_i && latch_s |=> sdi_o == $past(vlim_reg))
        else $error("limit flag not returned");
    AST_FLAG_CAUSE: assert property (ce_i ##1 ce_i && latch_s |=> sdi_o == $past(over_w, 2))
        else $error("limit flag does not follow comparator");
    AST_STORE: assert property (s_store |=> par_reg == $past(shift_reg))
        else $error("latch did not store chain");
    AST_HOLD: assert property (!(s_store) |=> $stable(par_reg))
        else $error("stored outputs moved between strobes");
    AST_HIZ: assert property (ce_i && !pwr_s |=> !par_oe_o)
        else $error("outputs driven during power event");
    AST_RELAY_ONE: assert property ($onehot(range_relay_o))
        else $error("not exactly one relay closed");

    // ==========================================================
    // Hold, wake and event checks
    // Waking needs a store and good power, so a half-loaded chain never drives
    sequence s_wake;
        ce_i && latch_rise && pwr_s;
    endsequence

    AST_OE_WAKE: assert property (s_wake |=> par_oe_o)
        else $error("outputs not driven after store");
    AST_OE_ASLEEP: assert property (ce_i && !latch_rise && !par_oe_o |=> !par_oe_o)
        else $error("outputs woke without a store");
    AST_PWR_EVENT: assert property (ce_i && pwr_fall |=> status_reg[`ISC_EV_PWRLOSS])
        else $error("power loss not recorded");
    AST_LIMIT_REG: assert property (ce_i |=> vlimit_o == $past(over_w))
        else $error("limit flag late");
    AST_SHIFT_IDLE: assert property (ce_i && !sclk_rise |=> $stable(shift_reg))
        else $error("chain moved without serial clock");
    AST_STORE_EVENT: assert property (s_store |=> status_reg[`ISC_EV_STORED])
        else $error("store event not recorded");
    AST_FROZEN: assert property (!ce_i |=> $stable({shift_reg, par_reg, hiz_reg}))
        else $error("state moved while clock enable low");
    AST_SW_NONE: assert property (|(range_relay_o & 5'h0A) |-> range_sw_o == 2'h0)
        else $error("switch driven on unshared relay");
    AST_SW_PICK: assert property (|(range_relay_o & 5'h15) |-> $onehot(range_sw_o))
        else $error("shared relay without one switch");
endmodule

// file: sim/isc_link_host.sv
// Behavioural isolated controller that drives the serial control link
module isc_link_host
    import isc_pkg::*;
(
    input wire logic clk_i,
    input wire logic sdi_i,
    output logic sclk_o,
    output logic latch_o,
    output logic sdo_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Link driver
    // Isolation hands the returned line over inverted
    logic rx_inv;
    assign rx_inv = ~sdi_i;
    initial begin
        sclk_o = 1'b0;
        latch_o = 1'b0;
        sdo_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Latch stays high afterwards so the limit flag can be read
    task automatic send_frame(input isc_frame_t f, output isc_frame_t ret);
        latch_o <= 1'b0;
        hold(6);
        for (int i = 23; i >= 0; i--) begin
            sdo_o <= f[i];
            hold(4);
            // Return line settled edges ago; reading it at its own update edge would race
            ret[i] = ~rx_inv;
            sclk_o <= 1'b1;
            hold(4);
            sclk_o <= 1'b0;
        end
        // Released data line shows the opposite level, not the last bit
        sdo_o <= ~f[0];
        hold(4);
        latch_o <= 1'b1;
        hold(8);
    endtask
    function automatic logic flag();
        return ~rx_inv;
    endfunction
endmodule

// file: sim/tb.sv
// Self-checking bench for the serial source control block
module tb
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Signals and instances
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic pwr_ok_i = 1'b0;
    logic [8:0] meas_volt_i = 9'h000;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ce_i = 1'b1;
    logic sclk, latch, sdo, sdi_o, sign_neg_o, par_oe_o, vlimit_o, irq_o;
    logic [11:0] level_code_o;
    logic [7:0] comp_code_o, rdata_o;
    logic [4:0] range_relay_o;
    logic [1:0] range_sw_o;
    isc_frame_t ret, f, prev;
    logic [8:0] mv [4] = '{9'h006, 9'h1FA, 9'h005, 9'h1FB};
    logic fl [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [4:0] rly [8] = '{5'h01, 5'h01, 5'h02, 5'h04, 5'h04, 5'h08, 5'h10, 5'h10};
    logic [1:0] sw [8] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    always #50 clk_i = ~clk_i;
    isc_ctrl i_isc_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sclk_i(sclk),
        .latch_i(latch), .sdo_i(sdo), .pwr_ok_i(pwr_ok_i), .meas_volt_i(meas_volt_i),
        .sdi_o(sdi_o), .level_code_o(level_code_o), .sign_neg_o(sign_neg_o),
        .comp_code_o(comp_code_o), .range_relay_o(range_relay_o), .range_sw_o(range_sw_o),
        .par_oe_o(par_oe_o), .vlimit_o(vlimit_o), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    isc_link_host i_isc_link_host (.clk_i(clk_i), .sdi_i(sdi_o), .sclk_o(sclk),
        .latch_o(latch), .sdo_o(sdo));
    // ====================
    // Tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // Return one edge after the write lands, so later stimulus stays on rising edges
        @(posedge clk_i);
    endtask
    task automatic reg_chk(input logic [1:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        check(rdata_o, exp, msg);
        @(posedge clk_i);
    endtask
    // Generous ceiling: the run needs about 2400 cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            test_done();
        end
    end
    // ====================
    // Tests
    initial begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        check(par_oe_o, 1'b0, "oe at reset");
        check(range_relay_o, 5'h01, "relay at reset");
        check(range_sw_o, 2'h1, "switch at reset");
        reg_chk(2'h0, 8'h00, "status at reset");
        $display("test reset done");
        pwr_ok_i <= 1'b1;
        prev = {3'h2, 8'h05, 1'b1, 12'hA5C};
        i_isc_link_host.send_frame(prev, ret);
        check(level_code_o, 12'hA5C, "level");
        check(sign_neg_o, 1'b1, "sign");
        check(comp_code_o, 8'h05, "compliance");
        check(par_oe_o, 1'b1, "oe after store");
        reg_chk(2'h3, 8'h02, "range code");
        reg_chk(2'h0, 8'h02, "stored event");
        reg_wr(2'h1, 8'h03);
        check(irq_o, 1'b1, "irq on stored");
        reg_wr(2'h0, 8'h02);
        check(irq_o, 1'b0, "irq cleared");
        $display("test store done");
        foreach (mv[k]) begin
            meas_volt_i <= mv[k];
            repeat (6) @(posedge clk_i);
            check(i_isc_link_host.flag(), fl[k], "limit flag");
            check(vlimit_o, fl[k], "vlimit");
        end
        reg_chk(2'h0, 8'h01, "limit event");
        check(irq_o, 1'b1, "irq on limit");
        reg_chk(2'h2, 8'h0A, "state word");
        $display("test limit done");
        for (int r = 0; r < 8; r++) begin
            f = {r[2:0], 8'h10 + 8'(r), 1'b0, 12'h300 + 12'(r)};
            i_isc_link_host.send_frame(f, ret);
            check(ret, prev, "recirculated");
            check(range_relay_o, rly[r], "relay");
            check(range_sw_o, sw[r], "switch");
            prev = f;
        end
        $display("test range done");
        fork
            i_isc_link_host.send_frame(24'hFFFFFF, ret);
            begin
                repeat (150) @(posedge clk_i);
                check(level_code_o, 12'h307, "held while shifting");
            end
        join
        check(level_code_o, 12'hFFF, "new level");
        pwr_ok_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check(par_oe_o, 1'b0, "hiz on power loss");
        reg_chk(2'h0, 8'h07, "power loss event");
        pwr_ok_i <= 1'b1;
        i_isc_link_host.send_frame(24'h000000, ret);
        check(par_oe_o, 1'b1, "oe restored");
        check(ret, 24'hFFFFFF, "recirculated after power loss");
        $display("test power done");
        // Clock enable low: a mask write must be ignored
        ce_i <= 1'b0;
        reg_wr(2'h1, 8'h00);
        check(irq_o, 1'b1, "mask write while frozen");
        ce_i <= 1'b1;
        reg_wr(2'h1, 8'h00);
        reg_chk(2'h1, 8'h00, "mask after thaw");
        check(irq_o, 1'b0, "irq masked");
        $display("test freeze done");
        test_done();
    end
endmodule
